// *** design/reset_source_controller.sv ***
// Reset source controller with cause flags on an AHB-Lite slave
`timescale 1ns/1ps

// Contract
// - Reset loads registers; restart at vector
// - Ports reset asynchronously on power-on or pin, one clock later on watchdog or brown-out
// - Delay counter stretches reset, fuse selected
// - Pin, watchdog and brown-out ORed into reset request; power-on acts through por_n
// - Supply below power-on level resets immediately
// - Power-on threshold reached starts delay counter
// - Long low pin pulse resets without clock
// - Pin rising starts delay, then release
// - Enabled brown-out below level resets after the filter count
// - Level fuse picks low or high trigger
// - Brown-out only after minimum low period
// - Supply recovery starts delay after brown-out
// - Watchdog pulse one cycle; delay after it
// - Watchdog resets only while enabled
// - Watchdog flag bit 3, write-zero clear
// - Brown-out flag bit 2, write-zero clear
// - Pin flag bit 1, write-zero clear
// - Power-on flag bit 0, software clear only
module reset_source_controller #(
	parameter int unsigned TOUT_SHORT_CYC = reset_source_pkg::TOUT_SHORT_US * reset_source_pkg::CLK_MHZ,
	parameter int unsigned TOUT_LONG_CYC  = reset_source_pkg::TOUT_LONG_US * reset_source_pkg::CLK_MHZ
) (
	// Clock and bus reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// Reset sources
	input  wire logic        vcc_below_por,
	input  wire logic        reset_pin_n,
	input  wire logic        wdt_expire,
	input  wire logic        wdt_enable,
	input  wire logic        vcc_below_bot,
	// Fuses
	input  wire logic [3:0]  clock_select_fuses,
	input  wire logic        brownout_enable_fuse,
	input  wire logic        brownout_level_fuse,
	// Reset outputs
	output logic             port_reset_n,
	output logic             cpu_reset_n,
	output logic             pc_load,
	output logic [15:0]      pc_vector,
	output logic             brownout_level_high
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic                                por_n;
	logic                                src_n;
	logic                                request;
	logic                                done_q;
	logic [reset_source_pkg::CNT_W-1:0]  limit;
	logic                                wdt_pulse_q;
	logic [$clog2(reset_source_pkg::BROWNOUT_CYC+1)-1:0] dip_cnt_q;
	logic                                brownout_q;
	logic [7:0]                          cause_q;
	logic [7:0]                          cause_d;
	logic [3:0]                          set_flags;
	logic [3:0]                          clr_flags;
	logic                                wr_pend_q;
	logic [7:0]                          wr_addr_q;
	logic                                rd_take;
	logic                                wr_take;
	logic                                cause_wr;
	logic                                cpu_reset_n_d;
	logic [7:0]                          src_status;

	// ----------------------------------------------------------------
	// Source combination
	// ----------------------------------------------------------------

	// Power-on domain reset: bus reset or supply below detection level
	assign por_n = hresetn & ~vcc_below_por;

	// Asynchronous sources that need no clock
	assign src_n = por_n & reset_pin_n;

	// Synchronous part of the request; power-on acts through por_n
	assign request = ~reset_pin_n | wdt_pulse_q | brownout_q;

	// Time-out selection from the clock select fuses
	always_comb begin
		case (clock_select_fuses[1:0])
			2'h0:    limit = reset_source_pkg::CNT_W'(reset_source_pkg::TOUT_MIN_CYC);
			2'h1:    limit = reset_source_pkg::CNT_W'(TOUT_SHORT_CYC);
			default: limit = reset_source_pkg::CNT_W'(TOUT_LONG_CYC);
		endcase
	end

	// ----------------------------------------------------------------
	// Watchdog pulse
	// ----------------------------------------------------------------

	// One-cycle pulse, only while the watchdog is enabled
	always_ff @(posedge hclk or negedge por_n) begin
		if (!por_n) begin
			wdt_pulse_q <= 1'b0;
		end else begin
			wdt_pulse_q <= wdt_expire & wdt_enable & ~wdt_pulse_q;
		end
	end

	// ----------------------------------------------------------------
	// Brown-out filter
	// ----------------------------------------------------------------

	// Threshold choice goes to the analogue detector
	always_ff @(posedge hclk or negedge por_n) begin
		if (!por_n) begin
			brownout_level_high <= 1'b0;
		end else begin
			brownout_level_high <= brownout_level_fuse;
		end
	end

	// Count low-supply cycles; short dips never reach the limit
	always_ff @(posedge hclk or negedge por_n) begin
		if (!por_n) begin
			dip_cnt_q  <= '0;
			brownout_q <= 1'b0;
		end else if (!(vcc_below_bot && brownout_enable_fuse)) begin
			dip_cnt_q  <= '0;
			brownout_q <= 1'b0;
		end else begin
			if (dip_cnt_q != $bits(dip_cnt_q)'(reset_source_pkg::BROWNOUT_CYC)) begin
				dip_cnt_q <= dip_cnt_q + 1'b1;
			end
			brownout_q <= (dip_cnt_q == $bits(dip_cnt_q)'(reset_source_pkg::BROWNOUT_CYC));
		end
	end

	// ----------------------------------------------------------------
	// Delay counter
	// ----------------------------------------------------------------

	// Starts once power-on, pin, watchdog and brown-out have all ended
	reset_stretch_counter u_stretch (
		.hclk   (hclk),
		.por_n  (por_n),
		.hold   (request),
		.limit  (limit),
		.done_q (done_q)
	);

	// ----------------------------------------------------------------
	// Reset outputs
	// ----------------------------------------------------------------

	assign cpu_reset_n_d = ~request & done_q;

	// Port reset drops asynchronously on power-on or pin
	always_ff @(posedge hclk or negedge src_n) begin
		if (!src_n) begin
			port_reset_n <= 1'b0;
		end else begin
			port_reset_n <= ~(wdt_pulse_q | brownout_q);
		end
	end

	// Internal reset, stretched by the delay counter
	always_ff @(posedge hclk or negedge src_n) begin
		if (!src_n) begin
			cpu_reset_n <= 1'b0;
			pc_load     <= 1'b0;
		end else begin
			cpu_reset_n <= cpu_reset_n_d;
			pc_load     <= cpu_reset_n_d & ~cpu_reset_n;
		end
	end

	// Start address presented with the load strobe
	always_ff @(posedge hclk or negedge por_n) begin
		if (!por_n) begin
			pc_vector <= 16'h0000;
		end else begin
			pc_vector <= reset_source_pkg::RESET_VECTOR;
		end
	end

	// ----------------------------------------------------------------
	// Cause flags
	// ----------------------------------------------------------------

	// Hardware events; set wins over a clear in the same cycle
	always_comb begin
		set_flags = 4'h0;
		set_flags[reset_source_pkg::WATCHDOG_BIT] = wdt_pulse_q;
		set_flags[reset_source_pkg::BROWNOUT_BIT] = brownout_q;
		set_flags[reset_source_pkg::PIN_BIT]      = ~reset_pin_n;
	end

	// Writing zero clears a flag, writing one leaves it
	assign cause_wr  = wr_pend_q && (wr_addr_q == reset_source_pkg::CAUSE_ADDR);
	assign clr_flags = cause_wr ? (~hwdata[3:0] & reset_source_pkg::FLAG_MASK) : 4'h0;
	assign cause_d   = {4'h0, (cause_q[3:0] & ~clr_flags) | set_flags};

	// Power-on sets bit 0 and clears the others
	always_ff @(posedge hclk or negedge por_n) begin
		if (!por_n) begin
			cause_q <= reset_source_pkg::CAUSE_RESET;
		end else begin
			cause_q <= cause_d;
		end
	end

	// Live source view for software
	always_comb begin
		src_status = 8'h00;
		src_status[reset_source_pkg::SRC_SUPPLY_BIT] = vcc_below_por;
		src_status[reset_source_pkg::SRC_PIN_BIT]    = ~reset_pin_n;
		src_status[reset_source_pkg::SRC_BROWNOUT_BIT] = brownout_q;
		src_status[reset_source_pkg::SRC_WDT_EN_BIT] = wdt_enable;
		src_status[reset_source_pkg::SRC_DONE_BIT]   = done_q;
	end

	// ----------------------------------------------------------------
	// AHB-Lite slave
	// ----------------------------------------------------------------

	assign wr_take = hsel && hready && (htrans == reset_source_pkg::TRANS_NONSEQ) && hwrite;
	assign rd_take = hsel && hready && (htrans == reset_source_pkg::TRANS_NONSEQ) && !hwrite;

	// Address phase capture for writes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end else if (hready) begin
			wr_pend_q <= wr_take;
			wr_addr_q <= {haddr[7:2], 2'h0};
		end
	end

	// Read data registered at the address phase, from next flag state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (rd_take) begin
			case ({haddr[7:2], 2'h0})
				reset_source_pkg::CAUSE_ADDR:  hrdata <= {24'h000000, cause_d};
				reset_source_pkg::SOURCE_ADDR: hrdata <= {24'h000000, src_status};
				default:                       hrdata <= 32'h0000_0000;
			endcase
		end else begin
			hrdata <= 32'h0000_0000;
		end
	end

	// Zero wait states and OKAY always
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= reset_source_pkg::RESP_OKAY;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= reset_source_pkg::RESP_OKAY;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------

	sequence s_wdt_pulse;
		wdt_pulse_q ##1 !wdt_pulse_q;
	endsequence

	property p_wdt_pulse;
		@(posedge hclk) disable iff (!por_n)
		(wdt_expire && wdt_enable && !wdt_pulse_q) |=> s_wdt_pulse;
	endproperty
	a_wdt_pulse: assert property (p_wdt_pulse) else $error("watchdog pulse not one cycle");

	property p_wdt_gate;
		@(posedge hclk) disable iff (!por_n)
		!wdt_enable |=> !wdt_pulse_q;
	endproperty
	a_wdt_gate: assert property (p_wdt_gate) else $error("watchdog reset while disabled");

	property p_dip_filter;
		@(posedge hclk) disable iff (!por_n)
		$rose(brownout_q) |-> $past(vcc_below_bot && brownout_enable_fuse, 2)
			&& $past(dip_cnt_q) == 6'(reset_source_pkg::BROWNOUT_CYC);
	endproperty
	a_dip_filter: assert property (p_dip_filter) else $error("brown-out without full low period");

	property p_brownout_clear;
		@(posedge hclk) disable iff (!por_n)
		!vcc_below_bot |=> !brownout_q;
	endproperty
	a_brownout_clear: assert property (p_brownout_clear) else $error("brown-out held after recovery");

	property p_wdt_flag;
		@(posedge hclk) disable iff (!por_n)
		wdt_pulse_q |=> cause_q[reset_source_pkg::WATCHDOG_BIT];
	endproperty
	a_wdt_flag: assert property (p_wdt_flag) else $error("watchdog flag not set");

	property p_brownout_flag;
		@(posedge hclk) disable iff (!por_n)
		brownout_q |=> cause_q[reset_source_pkg::BROWNOUT_BIT];
	endproperty
	a_brownout_flag: assert property (p_brownout_flag) else $error("brown-out flag not set");

	property p_pin_flag;
		@(posedge hclk) disable iff (!por_n)
		!reset_pin_n |=> cause_q[reset_source_pkg::PIN_BIT] && !cpu_reset_n;
	endproperty
	a_pin_flag: assert property (p_pin_flag) else $error("pin flag or reset missing");

	property p_por_flag;
		@(posedge hclk) disable iff (!por_n)
		$fell(cause_q[reset_source_pkg::POWERUP_BIT]) |-> $past(cause_wr && !hwdata[0]);
	endproperty
	a_por_flag: assert property (p_por_flag) else $error("power-on flag cleared by hardware");

	property p_release;
		@(posedge hclk) disable iff (!por_n)
		$rose(cpu_reset_n) |-> $past(done_q && !request) ##1 (cpu_reset_n && !pc_load);
	endproperty
	a_release: assert property (p_release) else $error("reset released before time-out");

	property p_port_reset;
		@(posedge hclk) disable iff (!por_n)
		(wdt_pulse_q || brownout_q) |=> !port_reset_n && !cpu_reset_n;
	endproperty
	a_port_reset: assert property (p_port_reset) else $error("source did not reset ports");

	property p_vector;
		@(posedge hclk) disable iff (!por_n)
		$rose(cpu_reset_n) |-> pc_load && pc_vector == reset_source_pkg::RESET_VECTOR;
	endproperty
	a_vector: assert property (p_vector) else $error("no vector load at release");

endmodule : reset_source_controller

// *** design/reset_source_pkg.sv ***
// Constants shared by the reset source controller and its delay counter
package reset_source_pkg;

	// ----------------------------------------------------------------
	// Register map (word aligned byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] CAUSE_ADDR  = 8'h00;
	localparam logic [7:0] SOURCE_ADDR = 8'h04;

	// ----------------------------------------------------------------
	// Cause register fields and reset value
	// ----------------------------------------------------------------
	localparam int         POWERUP_BIT  = 0;
	localparam int         PIN_BIT      = 1;
	localparam int         BROWNOUT_BIT = 2;
	localparam int         WATCHDOG_BIT = 3;
	localparam logic [3:0] FLAG_MASK    = 4'hf;
	localparam logic [7:0] CAUSE_RESET  = 8'h01;

	// ----------------------------------------------------------------
	// Source status register fields
	// ----------------------------------------------------------------
	localparam int SRC_SUPPLY_BIT   = 0;
	localparam int SRC_PIN_BIT      = 1;
	localparam int SRC_BROWNOUT_BIT = 2;
	localparam int SRC_WDT_EN_BIT   = 3;
	localparam int SRC_DONE_BIT     = 4;

	// ----------------------------------------------------------------
	// Bus encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] TRANS_NONSEQ = 2'h2;
	localparam logic       RESP_OKAY    = 1'h0;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_NS       = 40;
	localparam int CLK_MHZ      = 25;
	localparam int BROWNOUT_MIN_NS = 2000;
	localparam int BROWNOUT_CYC    = (BROWNOUT_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W        = 21;
	localparam int TOUT_SHORT_US = 4100;
	localparam int TOUT_LONG_US  = 65000;
	localparam int TOUT_MIN_CYC  = 1;
	localparam logic [15:0] RESET_VECTOR = 16'h0000;

endpackage : reset_source_pkg

// *** design/reset_stretch_counter.sv ***
// Delay counter that stretches the internal reset after all sources end
`timescale 1ns/1ps

module reset_stretch_counter (
	// Clock and power-on reset
	input  wire logic                                hclk,
	input  wire logic                                por_n,
	// Control
	input  wire logic                                hold,
	input  wire logic [reset_source_pkg::CNT_W-1:0]  limit,
	// Result
	output logic                                     done_q
);

	logic [reset_source_pkg::CNT_W-1:0] count_q;

	// Restart from zero while held, count up to the limit otherwise
	always_ff @(posedge hclk or negedge por_n) begin
		if (!por_n) begin
			count_q <= '0;
			done_q  <= 1'b0;
		end else if (hold) begin
			count_q <= '0;
			done_q  <= 1'b0;
		end else if (count_q >= limit - 1'b1) begin
			done_q  <= 1'b1;
		end else begin
			count_q <= count_q + 1'b1;
		end
	end

	property p_restart;
		@(posedge hclk) disable iff (!por_n)
		hold |=> (count_q == '0) && !done_q;
	endproperty
	a_restart: assert property (p_restart) else $error("delay counter did not restart");

endmodule : reset_stretch_counter

// *** sim/reset_source_model.sv ***
// Behavioural model of the reset pin, supply detectors and watchdog
`timescale 1ns/1ps

module reset_source_model #(
	parameter int PIN_MIN_CYC = 38
) (
	// Clock
	input  wire logic hclk,
	// Source levels
	output logic      vcc_below_por,
	output logic      reset_pin_n,
	output logic      wdt_expire,
	output logic      wdt_enable,
	output logic      vcc_below_bot
);

	// ----------------------------------------------------------------
	// Quiet levels at time zero
	// ----------------------------------------------------------------
	initial begin
		vcc_below_por = 1'b0;
		reset_pin_n   = 1'b1;
		wdt_expire    = 1'b0;
		wdt_enable    = 1'b0;
		vcc_below_bot = 1'b0;
	end

	// Pin pulse never shorter than the guaranteed width
	task automatic pin_reset(input int cyc);
		int n;
		n = (cyc < PIN_MIN_CYC) ? PIN_MIN_CYC : cyc;
		@(posedge hclk);
		reset_pin_n <= 1'b0;
		repeat (n) @(posedge hclk);
		reset_pin_n <= 1'b1;
	endtask : pin_reset

	// Both supply detector levels
	task automatic supply(input logic por, input logic brown);
		@(posedge hclk);
		vcc_below_por <= por;
		vcc_below_bot <= brown;
	endtask : supply

	// Watchdog enable level and expiry held a number of cycles
	task automatic watchdog(input logic en, input int cyc);
		@(posedge hclk);
		wdt_enable <= en;
		wdt_expire <= 1'b1;
		repeat (cyc) @(posedge hclk);
		wdt_expire <= 1'b0;
	endtask : watchdog

endmodule : reset_source_model

// *** sim/test_reset_source_controller.sv ***
// Self-checking bench for the reset source controller
`timescale 1ns/1ps

`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin fails++; \
	$display("unexpected %s expected %h seen %h", nm, exp, got); end end

module test_reset_source_controller;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	localparam int SHORT_CYC = 20;
	localparam int LONG_CYC  = 40;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [3:0]  clock_select_fuses;
	logic        brownout_enable_fuse, brownout_level_fuse;
	logic        vcc_below_por, reset_pin_n, wdt_expire, wdt_enable, vcc_below_bot;
	logic        port_reset_n, cpu_reset_n, pc_load, brownout_level_high;
	logic [15:0] pc_vector;
	int          fails, check_count, n, lows, plows;
	int          lims [4] = '{1, SHORT_CYC, LONG_CYC, LONG_CYC};

	// Design and far-side model
	reset_source_controller #(.TOUT_SHORT_CYC(SHORT_CYC), .TOUT_LONG_CYC(LONG_CYC)) u_reset_source_controller (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .vcc_below_por(vcc_below_por), .reset_pin_n(reset_pin_n),
		.wdt_expire(wdt_expire), .wdt_enable(wdt_enable), .vcc_below_bot(vcc_below_bot),
		.clock_select_fuses(clock_select_fuses), .brownout_enable_fuse(brownout_enable_fuse),
		.brownout_level_fuse(brownout_level_fuse), .port_reset_n(port_reset_n),
		.cpu_reset_n(cpu_reset_n), .pc_load(pc_load), .pc_vector(pc_vector),
		.brownout_level_high(brownout_level_high));
	reset_source_model u_reset_source_model (
		.hclk(hclk), .vcc_below_por(vcc_below_por), .reset_pin_n(reset_pin_n),
		.wdt_expire(wdt_expire), .wdt_enable(wdt_enable), .vcc_below_bot(vcc_below_bot));

	// 25 MHz clock
	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : conclude

	// Bounded wait for the bus ready
	task automatic ready_wait();
		int k;
		k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while (hreadyout !== 1'b1 && k < 50);
		if (k >= 50) begin
			fails++;
			conclude();
		end
	endtask : ready_wait

	// One single word transfer, read data lands in rd
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= {24'h000000, a};
		htrans <= reset_source_pkg::TRANS_NONSEQ;
		hwrite <= w;
		ready_wait();
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		ready_wait();
		rd = hrdata;
	endtask : bus

	task automatic reg_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h00000000);
		`CHK(nm, exp, rd)
		`CHK("response", reset_source_pkg::RESP_OKAY, hresp)
	endtask : reg_chk

	// Cycles until the internal reset is seen released
	task automatic wait_cpu();
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (cpu_reset_n !== 1'b1 && n < 300);
		if (n >= 300) begin
			fails++;
			conclude();
		end
	endtask : wait_cpu

	// Count cycles with internal and port reset low
	task automatic count_low(input int c);
		lows = 0;
		plows = 0;
		repeat (c) begin
			@(posedge hclk);
			if (cpu_reset_n !== 1'b1) lows++;
			if (port_reset_n !== 1'b1) plows++;
		end
	endtask : count_low

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		clock_select_fuses = 4'h1;
		brownout_enable_fuse = 1'b1;
		brownout_level_fuse = 1'b0;
		fails = 0;
		check_count = 0;
		repeat (3) @(posedge hclk);
		`CHK("port reset", 1'b0, port_reset_n)
		hresetn <= 1'b1;
		wait_cpu();
		`CHK("start delay", 1'b1, n >= SHORT_CYC && n <= SHORT_CYC + 4)
		`CHK("vector load", 1'b1, pc_load)
		`CHK("vector", reset_source_pkg::RESET_VECTOR, pc_vector)
		`CHK("level out", 1'b0, brownout_level_high)
		reg_chk("cause", reset_source_pkg::CAUSE_ADDR, 32'h00000001);
		bus(1'b1, reset_source_pkg::CAUSE_ADDR, 32'h00000000);
		reg_chk("cause", reset_source_pkg::CAUSE_ADDR, 32'h00000000);
		reg_chk("unmapped", 8'h08, 32'h00000000);
		$display("test powerup done");
		// Watchdog disabled, then one enabled expiry
		u_reset_source_model.watchdog(1'b0, 5);
		count_low(8);
		`CHK("wdt disabled", 0, lows)
		u_reset_source_model.watchdog(1'b1, 1);
		count_low(8);
		`CHK("wdt pulse", 1, plows)
		wait_cpu();
		`CHK("wdt delay", 1'b1, n + 8 >= SHORT_CYC && n + 8 <= SHORT_CYC + 6)
		reg_chk("sources", reset_source_pkg::SOURCE_ADDR, 32'h00000018);
		reg_chk("cause", reset_source_pkg::CAUSE_ADDR, 32'h00000008);
		$display("test watchdog done");
		// Pin reset, reasserted while the delay runs
		fork
			u_reset_source_model.pin_reset(1);
			begin @(posedge hclk); #2 `CHK("async port", 1'b0, port_reset_n) end
		join
		repeat (10) @(posedge hclk);
		u_reset_source_model.pin_reset(1);
		count_low(SHORT_CYC - 5);
		`CHK("restart", SHORT_CYC - 5, lows)
		wait_cpu();
		reg_chk("cause", reset_source_pkg::CAUSE_ADDR, 32'h0000000a);
		$display("test pin done");
		// Brown-out: short dip, disabled detector, real drop
		u_reset_source_model.supply(1'b0, 1'b1);
		count_low(reset_source_pkg::BROWNOUT_CYC - 5);
		u_reset_source_model.supply(1'b0, 1'b0);
		`CHK("short dip", 0, lows)
		brownout_enable_fuse <= 1'b0;
		u_reset_source_model.supply(1'b0, 1'b1);
		count_low(reset_source_pkg::BROWNOUT_CYC + 10);
		u_reset_source_model.supply(1'b0, 1'b0);
		`CHK("brownout disabled", 0, lows)
		brownout_enable_fuse <= 1'b1;
		brownout_level_fuse <= 1'b1;
		u_reset_source_model.supply(1'b0, 1'b1);
		count_low(reset_source_pkg::BROWNOUT_CYC + 10);
		`CHK("brownout reset", 1'b1, lows > 0 && cpu_reset_n === 1'b0)
		`CHK("level out", 1'b1, brownout_level_high)
		u_reset_source_model.supply(1'b0, 1'b0);
		wait_cpu();
		`CHK("brownout delay", 1'b1, n >= SHORT_CYC && n <= SHORT_CYC + 4)
		reg_chk("cause", reset_source_pkg::CAUSE_ADDR, 32'h0000000e);
		bus(1'b1, reset_source_pkg::CAUSE_ADDR, 32'h0000000b);
		reg_chk("cause", reset_source_pkg::CAUSE_ADDR, 32'h0000000a);
		$display("test brownout done");
		// Power-on reset with every delay choice
		for (int s = 0; s < 4; s++) begin
			clock_select_fuses <= 4'(s);
			u_reset_source_model.supply(1'b1, 1'b0);
			#2 `CHK("por port", 1'b0, port_reset_n)
			repeat (3) @(posedge hclk);
			u_reset_source_model.supply(1'b0, 1'b0);
			wait_cpu();
			`CHK("por delay", 1'b1, n >= lims[s] && n <= lims[s] + 4)
		end
		reg_chk("cause", reset_source_pkg::CAUSE_ADDR, 32'h00000001);
		$display("test poweron done");
		conclude();
	end

endmodule : test_reset_source_controller
